// ---- rtl/rx_framer_status_params.svh ----
// offsets, field positions, reset values and limits of the receive status bank
//=============================================================================
`ifndef RX_FRAMER_STATUS_PARAMS_SVH
`define RX_FRAMER_STATUS_PARAMS_SVH

//=============================================================================
// register indices within one port (byte address = 4 x index)
`define EBIT_HIGH_IDX      9'h056
`define EBIT_LOW_IDX       9'h057
`define CHAN_MON_IDX       9'h060
`define FW_REV_IDX         9'h061
`define LINK_STATUS_IDX    9'h062
`define BOC_IDX            9'h063
`define PORT_CTRL_IDX      9'h070
`define PORT_STRIDE_IDX    12'h200

//=============================================================================
// control register fields
`define CTRL_E1_MODE_BIT   0
`define CTRL_CRC4_EN_BIT   1
`define CTRL_D4_BIT        2
`define CTRL_SEL_LSB       8
`define CTRL_SEL_MSB       12
`define CTRL_WR_MASK       32'h0000_1f07
`define CTRL_RESET         32'h0000_0000

//=============================================================================
// counters and reset values
`define EBIT_MAX           16'hffff
`define CSC_MAX            6'h3f
`define BYTE_RESET         8'h00
`define FW_REV_DEFAULT     8'h01
`define MAX_PORTS          8

`endif

// ---- rtl/rx_framer_status_pkg.sv ----
// types shared by the receive status bank
package rx_framer_status_pkg;

  // per-port events and levels from the receive framer, same clock
  typedef struct packed {
    logic       bit_stb;
    logic       bit_val;
    logic [4:0] slot;
    logic       slot_last;
    logic       ebit_error;
    logic       crc4_timeout;
    logic       crc4_mf_locked;
    logic       crc4_hunt;
    logic       cas_hunt;
    logic       fas_hunt;
    logic       fdl_stb;
    logic [7:0] fdl_byte;
    logic       fs_stb;
    logic       fs_bit;
    logic       mf_boundary;
    logic       boc_stb;
    logic [5:0] boc_code;
  } rx_event_t;

  typedef struct packed {
    logic       e1_mode;
    logic       crc4_mode_enable;
    logic       d4_framing;
    logic [4:0] channel_monitor_select;
  } port_ctrl_t;

endpackage : rx_framer_status_pkg

// ---- rtl/rx_framer_status_counters.sv ----
// receive status and count registers of all ports behind one APB slave
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "rx_framer_status_params.svh"

module rx_framer_status_counters #(
  parameter int unsigned      NPORTS = 8,
  parameter logic [7:0]       FW_REV = `FW_REV_DEFAULT  // arbitrary revision value
) (
  input  wire logic                              CLK,
  input  wire logic                              RST,
  input  wire logic                              PSEL,
  input  wire logic                              PENABLE,
  input  wire logic                              PWRITE,
  input  wire logic [15:0]                       PADDR,
  input  wire logic [31:0]                       PWDATA,
  output logic                                   PREADY,
  output logic [31:0]                            PRDATA,
  output logic                                   PSLVERR,
  input  wire rx_framer_status_pkg::rx_event_t   RX_EVENT [NPORTS]
);

  //===========================================================================
  // parameter checks at the start of simulation
  initial begin
    if (NPORTS < 1 || NPORTS > `MAX_PORTS) begin
      $error("NPORTS must lie between 1 and 8");
    end
  end

  //===========================================================================
  // address decode
  logic [13:0] word_idx;
  logic [2:0]  port_sel;
  logic [8:0]  reg_sel;
  logic        port_ok;
  logic        reg_ok;
  logic        setup_phase;
  logic        access_done;
  logic        rd_done;
  logic        wr_done;

  assign word_idx    = PADDR[15:2];
  assign port_sel    = word_idx[11:9];
  assign reg_sel     = word_idx[8:0];
  assign port_ok     = (word_idx[13:12] == 2'b00) && (PADDR[1:0] == 2'b00) &&
                       ({29'h0000_0000, port_sel} < NPORTS);
  assign setup_phase = PSEL && !PENABLE;
  assign access_done = PSEL && PENABLE;
  assign rd_done     = access_done && !PWRITE && port_ok;
  assign wr_done     = access_done && PWRITE && port_ok;

  always_comb begin
    case (reg_sel)
      `EBIT_HIGH_IDX,
      `EBIT_LOW_IDX,
      `CHAN_MON_IDX,
      `FW_REV_IDX,
      `LINK_STATUS_IDX,
      `BOC_IDX,
      `PORT_CTRL_IDX: reg_ok = 1'b1;
      default:        reg_ok = 1'b0;
    endcase
  end

  // every access completes in its first access cycle
  assign PREADY = 1'b1;

  //===========================================================================
  // per-port read views
  logic [31:0] port_rdata [NPORTS];

  genvar gp;
  generate
    for (gp = 0; gp < NPORTS; gp++) begin : gen_port
      rx_framer_status_pkg::rx_event_t  ev;
      rx_framer_status_pkg::port_ctrl_t ctrl_reg;
      logic [15:0] ebit_error_count_reg;
      logic [7:0]  ebit_low_snap_reg;
      logic [7:0]  mon_shift_reg;
      logic [7:0]  channel_monitor_byte_reg;
      logic [5:0]  fs_shift_reg;
      logic [5:0]  fs_shift_next;
      logic [7:0]  rx_link_byte_reg;
      logic [5:0]  crc4_search_timeout_count_reg;
      logic [5:0]  rx_bit_oriented_code_field_reg;
      logic [7:0]  sync_status;
      logic [7:0]  rd_byte;
      logic        this_port;

      assign ev        = RX_EVENT[gp];
      assign this_port = (port_sel == 3'(gp));

      //=======================================================================
      // control: mode, CRC-4 enable, D4 framing, monitored channel
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          ctrl_reg <= '0;
        end else if (wr_done && this_port && reg_sel == `PORT_CTRL_IDX) begin
          ctrl_reg.e1_mode                <= PWDATA[`CTRL_E1_MODE_BIT];
          ctrl_reg.crc4_mode_enable       <= PWDATA[`CTRL_CRC4_EN_BIT];
          ctrl_reg.d4_framing             <= PWDATA[`CTRL_D4_BIT];
          ctrl_reg.channel_monitor_select <= PWDATA[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
        end
      end

      //=======================================================================
      // far-end block error count, saturating
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          ebit_error_count_reg <= '0;
        end else if (ctrl_reg.e1_mode && ctrl_reg.crc4_mode_enable &&
                     ev.ebit_error && ebit_error_count_reg != `EBIT_MAX) begin
          ebit_error_count_reg <= ebit_error_count_reg + 16'h0001;
        end
      end

      // reading the high byte freezes the low byte for the following read
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          ebit_low_snap_reg <= `BYTE_RESET;
        end else if (rd_done && this_port && reg_sel == `EBIT_HIGH_IDX) begin
          ebit_low_snap_reg <= ebit_error_count_reg[7:0];
        end
      end

      //=======================================================================
      // channel monitor: shift in the selected slot, first bit ends in bit 7
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          mon_shift_reg <= `BYTE_RESET;
        end else if (ev.bit_stb && ev.slot == ctrl_reg.channel_monitor_select) begin
          mon_shift_reg <= {mon_shift_reg[6:0], ev.bit_val};
        end
      end

      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          channel_monitor_byte_reg <= `BYTE_RESET;
        end else if (ev.bit_stb && ev.slot_last &&
                     ev.slot == ctrl_reg.channel_monitor_select) begin
          channel_monitor_byte_reg <= {mon_shift_reg[6:0], ev.bit_val};
        end
      end

      //=======================================================================
      // T1 link byte: whole code in ESF, Fs bits at multiframe edge in D4
      always_comb begin
        fs_shift_next = fs_shift_reg;
        if (ev.fs_stb) begin
          fs_shift_next = {ev.fs_bit, fs_shift_reg[5:1]};
        end
      end

      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          fs_shift_reg <= '0;
        end else begin
          fs_shift_reg <= fs_shift_next;
        end
      end

      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          rx_link_byte_reg <= `BYTE_RESET;
        end else if (ctrl_reg.d4_framing) begin
          if (ev.mf_boundary) begin
            rx_link_byte_reg <= {2'b00, fs_shift_next};
          end
        end else if (ev.fdl_stb) begin
          rx_link_byte_reg <= ev.fdl_byte;
        end
      end

      //=======================================================================
      // CRC-4 multiframe search timeout count
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          crc4_search_timeout_count_reg <= '0;
        end else if (!ctrl_reg.crc4_mode_enable) begin
          crc4_search_timeout_count_reg <= '0;
        end else if (ev.crc4_mf_locked) begin
          crc4_search_timeout_count_reg <= '0;
        end else if (ev.crc4_timeout &&
                     crc4_search_timeout_count_reg != `CSC_MAX) begin
          crc4_search_timeout_count_reg <= crc4_search_timeout_count_reg + 6'h01;
        end
      end

      // timeout count bits 5..2 and 0 over live hunt levels; only the count is registered
      assign sync_status = {crc4_search_timeout_count_reg[5:2],
                            crc4_search_timeout_count_reg[0],
                            ev.crc4_hunt,
                            ev.cas_hunt,
                            ev.fas_hunt};

      //=======================================================================
      // bit-oriented code: only a validated code replaces the held one
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          rx_bit_oriented_code_field_reg <= '0;
        end else if (ev.boc_stb) begin
          rx_bit_oriented_code_field_reg <= ev.boc_code;
        end
      end

      //=======================================================================
      // read view of this port
      always_comb begin
        rd_byte = `BYTE_RESET;
        case (reg_sel)
          `EBIT_HIGH_IDX: begin
            if (ctrl_reg.e1_mode) begin
              rd_byte = ebit_error_count_reg[15:8];
            end
          end
          `EBIT_LOW_IDX: begin
            if (ctrl_reg.e1_mode) begin
              rd_byte = ebit_low_snap_reg;
            end
          end
          `CHAN_MON_IDX: begin
            rd_byte = channel_monitor_byte_reg;
          end
          `FW_REV_IDX: begin
            if (ctrl_reg.e1_mode) begin
              rd_byte = FW_REV;
            end
          end
          `LINK_STATUS_IDX: begin
            if (ctrl_reg.e1_mode) begin
              rd_byte = sync_status;
            end else begin
              rd_byte = rx_link_byte_reg;
            end
          end
          `BOC_IDX: begin
            if (!ctrl_reg.e1_mode) begin
              rd_byte = {2'b00, rx_bit_oriented_code_field_reg};
            end
          end
          default: begin
            rd_byte = `BYTE_RESET;
          end
        endcase
      end

      always_comb begin
        if (reg_sel == `PORT_CTRL_IDX) begin
          port_rdata[gp] = {19'h00000, ctrl_reg.channel_monitor_select,
                            5'h00, ctrl_reg.d4_framing,
                            ctrl_reg.crc4_mode_enable, ctrl_reg.e1_mode};
        end else begin
          port_rdata[gp] = {24'h000000, rd_byte};
        end
      end
    end
  endgenerate

  //===========================================================================
  // bus answer, registered during the setup cycle
  logic [31:0] rdata_next;
  logic        slverr_next;

  always_comb begin
    rdata_next  = 32'h0000_0000;
    slverr_next = 1'b0;
    if (!port_ok || !reg_ok) begin
      slverr_next = 1'b1;
    end else if (!PWRITE) begin
      rdata_next = port_rdata[port_sel];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (setup_phase) begin
      PRDATA <= rdata_next;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PSLVERR <= 1'b0;
    end else if (setup_phase) begin
      PSLVERR <= slverr_next;
    end else if (access_done) begin
      PSLVERR <= 1'b0;
    end
  end

endmodule : rx_framer_status_counters

// ---- dv/rx_framer_status_counters_chk.sv ----
// bus-side assertion checker for the receive status bank
`timescale 1ns/1ps
`include "rx_framer_status_params.svh"
module rx_framer_status_chk #(
  parameter int unsigned NPORTS = 8
) (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic        PSLVERR,
  input wire rx_framer_status_pkg::rx_event_t RX_EVENT [NPORTS]
);
  //==========================================================================
  // decode and the mode of each port as written over the bus
  logic       setup;
  logic       mapped;
  logic [8:0] idx;
  logic [2:0] prt;
  logic [2:0] hunt;
  logic [7:0] e1_reg;
  assign setup = PSEL && !PENABLE;
  assign idx = PADDR[10:2];
  assign prt = PADDR[13:11];
  assign mapped = PADDR[1:0] == 2'h0 && PADDR[15:14] == 2'h0 && prt < NPORTS &&
    idx inside {`EBIT_HIGH_IDX, `EBIT_LOW_IDX, `CHAN_MON_IDX, `FW_REV_IDX,
                `LINK_STATUS_IDX, `BOC_IDX, `PORT_CTRL_IDX};
  assign hunt = {RX_EVENT[prt].crc4_hunt, RX_EVENT[prt].cas_hunt, RX_EVENT[prt].fas_hunt};
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      e1_reg <= 8'h00;
    end else if (PSEL && PENABLE && PWRITE && mapped && idx == `PORT_CTRL_IDX) begin
      e1_reg[prt] <= PWDATA[0];
    end
  end
  //==========================================================================
  // assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_ready_high: assert property (PREADY)
    else $error("pready low");
  a_bad_addr: assert property (setup && !mapped |=> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
  a_good_addr: assert property (setup && mapped |=> !PSLVERR)
    else $error("mapped access refused");
  a_err_window: assert property (PSLVERR |-> PSEL && PENABLE)
    else $error("error outside access phase");
  a_data_holds: assert property (!setup |=> $stable(PRDATA))
    else $error("read data changed without setup");
  a_byte_wide: assert property (setup && mapped && idx != `PORT_CTRL_IDX
    |=> PRDATA[31:8] == 24'h0)
    else $error("status register wider than a byte");
  a_boc_top: assert property (setup && mapped && idx == `BOC_IDX |=> PRDATA[7:6] == 2'b00)
    else $error("code bits 7..6 not zero");
  a_hunt_live: assert property (setup && mapped && idx == `LINK_STATUS_IDX && e1_reg[prt]
    |=> PRDATA[2:0] == $past(hunt))
    else $error("hunt bits not live");
  a_t1_rev_zero: assert property (setup && mapped && idx == `FW_REV_IDX && !e1_reg[prt]
    |=> PRDATA == 32'h0)
    else $error("revision visible outside E1");
endmodule : rx_framer_status_chk

bind rx_framer_status_counters rx_framer_status_chk #(.NPORTS(NPORTS)) chk_i (
  .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .RX_EVENT(RX_EVENT)
);

// ---- dv/rx_line_model.sv ----
// far-end line model for one port: line bits, framer strobes, hunt levels
`timescale 1ns/1ps
module rx_line_model (
  input  wire logic                       clk,
  output rx_framer_status_pkg::rx_event_t ev
);
  //==========================================================================
  // kinds: 0 e-bit, 1 search timeout, 2 lock, 3 link byte, 4 fs bit, 5 boundary, 6 code
  logic [6:0] stb = 7'h00;
  logic [7:0] dat = 8'h00;
  logic [2:0] hunt = 3'h0;
  logic       bstb = 1'b0;
  logic       bval = 1'b0;
  logic       blast = 1'b0;
  logic [4:0] bslot = 5'h00;
  always_comb begin
    ev = '0;
    ev.bit_stb = bstb;
    ev.bit_val = bval;
    ev.slot = bslot;
    ev.slot_last = blast;
    ev.ebit_error = stb[0];
    ev.crc4_timeout = stb[1];
    ev.crc4_mf_locked = stb[2];
    ev.fdl_stb = stb[3];
    ev.fs_stb = stb[4];
    ev.mf_boundary = stb[5];
    ev.boc_stb = stb[6];
    ev.fdl_byte = dat;
    ev.fs_bit = dat[0];
    ev.boc_code = dat[5:0];
    {ev.crc4_hunt, ev.cas_hunt, ev.fas_hunt} = hunt;
  end
  // data lines flip once the strobe is released
  task automatic strobe(input int k, input int n, input logic [7:0] d);
    @(posedge clk);
    stb <= 7'(1 << k);
    dat <= d;
    repeat (n) @(posedge clk);
    stb <= 7'h00;
    dat <= ~d;
  endtask : strobe
  task automatic send_slot(input logic [4:0] s, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk);
      bstb <= 1'b1;
      bval <= b[i];
      bslot <= s;
      blast <= i == 0;
    end
    @(posedge clk);
    bstb <= 1'b0;
    bval <= ~b[0];
  endtask : send_slot
endmodule : rx_line_model

// ---- dv/rx_framer_status_counters_tb_top.sv ----
// self-checking bench for the receive status bank
`timescale 1ns/1ps
`include "rx_framer_status_params.svh"
module rx_framer_status_counters_tb_top;
  typedef struct packed {
    logic [31:0] c;
    logic [2:0]  p;
    logic [8:0]  i;
    logic [31:0] e;
  } row_t;
  localparam logic [5:0] FS_BITS = 6'b001101;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [31:0] rdata;
  logic        rerr;
  int          err_count = 0;
  int          comparisons = 0;
  rx_framer_status_pkg::rx_event_t ev7;
  wire rx_framer_status_pkg::rx_event_t rx_ev [8];
  row_t rows [8] = '{
    '{32'h0, 3'd0, `EBIT_HIGH_IDX, 32'h0}, '{32'h0, 3'd0, `EBIT_LOW_IDX, 32'h0},
    '{32'h0, 3'd7, `FW_REV_IDX, 32'h0}, '{32'h1, 3'd7, `FW_REV_IDX, 32'(`FW_REV_DEFAULT)},
    '{32'h1, 3'd7, `BOC_IDX, 32'h0}, '{32'h1, 3'd7, `LINK_STATUS_IDX, 32'h0},
    '{32'hffff_ffff, 3'd7, `PORT_CTRL_IDX, `CTRL_WR_MASK}, '{32'h0, 3'd7, `CHAN_MON_IDX, 32'h0}};
  always #2 clk = ~clk;
  for (genvar g = 0; g < 7; g++) begin : g_idle
    assign rx_ev[g] = '0;
  end
  assign rx_ev[7] = ev7;
  rx_framer_status_counters dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .RX_EVENT(rx_ev));
  rx_line_model line (.clk(clk), .ev(ev7));
  //==========================================================================
  // bus and check tasks
  function automatic logic [15:0] ad(input int p, input logic [8:0] i);
    return 16'((p * `PORT_STRIDE_IDX + i) * 4);
  endfunction : ad
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      err_count++;
      $display("unexpected pready: expected 1, seen %b", pready);
      final_report();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input string nm, input int p, input logic [8:0] i, input logic [31:0] e);
    apb(1'b0, ad(p, i), 32'h0);
    chk(nm, rdata, e);
  endtask : rchk
  //==========================================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int r = 0; r < 8; r++) begin
      apb(1'b1, ad(rows[r].p, `PORT_CTRL_IDX), rows[r].c);
      rchk("row", rows[r].p, rows[r].i, rows[r].e);
    end
    apb(1'b1, ad(7, `PORT_CTRL_IDX), 32'h3);
    apb(1'b1, ad(7, `FW_REV_IDX), 32'h5a);
    rchk("fw_rev", 7, `FW_REV_IDX, 32'(`FW_REV_DEFAULT));
    line.strobe(0, 259, 8'h00);
    rchk("ebit_high", 7, `EBIT_HIGH_IDX, 32'h01);
    line.strobe(0, 2, 8'h00);
    rchk("ebit_low", 7, `EBIT_LOW_IDX, 32'h03);
    rchk("ebit_port0", 0, `EBIT_HIGH_IDX, 32'h00);
    line.hunt <= 3'b101;
    line.strobe(1, 5, 8'h00);
    rchk("sync", 7, `LINK_STATUS_IDX, 32'h1d);
    line.hunt <= 3'b010;
    line.strobe(2, 1, 8'h00);
    line.strobe(1, 2, 8'h00);
    rchk("sync", 7, `LINK_STATUS_IDX, 32'h02);
    line.strobe(1, 70, 8'h00);
    rchk("sync", 7, `LINK_STATUS_IDX, 32'hfa);
    apb(1'b1, ad(7, `PORT_CTRL_IDX), 32'h1);
    apb(1'b1, ad(7, `PORT_CTRL_IDX), 32'h3);
    rchk("sync", 7, `LINK_STATUS_IDX, 32'h02);
    apb(1'b1, ad(7, `PORT_CTRL_IDX), 32'h503);
    line.send_slot(5'd4, 8'h0f);
    line.send_slot(5'd5, 8'ha6);
    line.send_slot(5'd6, 8'hff);
    rchk("monitor", 7, `CHAN_MON_IDX, 32'ha6);
    apb(1'b1, ad(7, `PORT_CTRL_IDX), 32'h0);
    line.strobe(3, 1, 8'h81);
    rchk("link", 7, `LINK_STATUS_IDX, 32'h81);
    line.strobe(6, 1, 8'hea);
    rchk("code", 7, `BOC_IDX, 32'h2a);
    apb(1'b1, ad(7, `PORT_CTRL_IDX), 32'h4);
    for (int b = 0; b < 6; b++) line.strobe(4, 1, {7'h0, FS_BITS[b]});
    rchk("link", 7, `LINK_STATUS_IDX, 32'h81);
    line.strobe(5, 1, 8'h00);
    rchk("link", 7, `LINK_STATUS_IDX, 32'h0d);
    apb(1'b0, ad(7, 9'h058), 32'h0);
    chk("slverr", {31'h0, rerr}, 32'h1);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rchk("ctrl_reset", 7, `PORT_CTRL_IDX, `CTRL_RESET);
    apb(1'b1, ad(7, `PORT_CTRL_IDX), 32'h1);
    rchk("ebit_high", 7, `EBIT_HIGH_IDX, 32'h00);
    rchk("ebit_high", 7, `EBIT_HIGH_IDX, 32'h00);
    rchk("ebit_low", 7, `EBIT_LOW_IDX, 32'h00);
    final_report();
  end
endmodule : rx_framer_status_counters_tb_top
